// ---- rtl/scan_shifter_signature_counter.sv ----
// Scan data shifters, signature compactor and cycle counter behind APB.
// Operation
// (R1) Seed pattern generator with four bytes, LSB first.
// (R2) Accept seed writes; hold shifting until seeded.
// (R3) Loop-around bit routes TDI to TDO.
// (R4) Host puts partial outgoing bits lowest.
// (R5) Terminal count ends shift, drops leftover bits.
// (R6) Incoming shifter samples TDI on rising edge.
// (R7) Incoming read only when full, signature off.
// (R8) Incoming writes only in signature mode.
// (R9) Incoming shifts when enabled, not full, running.
// (R10) Incoming registers alternate per byte or count.
// (R11) Incoming bits enter at the MSB end.
// (R12) Signature mode compacts with 16-bit polynomial.
// (R13) Signature seeded MSB first; blocks shift, reads.
// (R14) Leaving signature mode marks full, MSB first.
// (R15) Loop-back select feeds outgoing stream back in.
// (R16) Loop-back never stops clock or outgoing shifting.
// (R17) Counter is 32-bit, loadable when disabled.
// (R18) Four byte writes; other address restarts loading.
// (R19) Counter resets at terminal count and reset.
// (R20) Soft reset leaves the counter untouched.
// (R21) All four counter segments read live.
// (R22) Single step decrements once, scan clock idle.
// (R23) Counter never wraps below zero.
// (R24) Pattern generator uses 32-bit polynomial.
// (R25) TDO changes on shift clock falling edge.
// (R26) Partial byte after terminal count is readable.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "scan_shifter_regs.svh"
module scan_shifter_signature_counter
	import scan_shifter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sck,
	input wire logic tdi,
	input wire logic tms0Stream,
	input wire logic tms1Stream,
	output logic tdo,
	output logic tck
);
	logic sck1_q, sck2_q, sck3_q, tdi1_q, tdi2_q;
	logic [7:0] cfg0_q, cfg1_q;
	enables_t enab_q;
	logic stepArm_q;
	logic [31:0] cnt_q;
	logic [1:0] cntPtr_q;
	logic [7:0] tdoBuf_q [2];
	logic [1:0] tdoFull_q;
	logic tdoWrSel_q, tdoShSel_q;
	logic [31:0] lfsr_q;
	logic [2:0] seedPtr_q;
	logic [7:0] tdiBuf_q [2];
	logic [1:0] tdiFull_q;
	logic tdiInSel_q, tdiRdSel_q;
	logic [15:0] sig_q;
	logic [1:0] sigPtr_q;
	logic [2:0] bitCnt_q;
	logic tdoPin_q, tck_q, ssc_q, pattern_generator_q;

	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire aCfg0 = paddr == `OFS_CFG0;
	wire aCfg1 = paddr == `OFS_CFG1;
	wire aCfg2 = paddr == `OFS_CFG2;
	wire aEnab = paddr == `OFS_ENAB;
	wire aTdo = paddr == `OFS_TDO;
	wire aTdi = paddr == `OFS_TDI;
	wire aCnt = paddr == `OFS_CNT;
	wire aStat = paddr == `OFS_STAT;
	wire aSeg = paddr >= `OFS_SEG0 && paddr <= `OFS_SEG3 &&
		paddr[1:0] == 2'h0;
	wire mapped = aCfg0 | aCfg1 | aCfg2 | aEnab | aTdo | aTdi | aCnt |
		aStat | aSeg;
	wire signature_compactor = cfg1_q[`CFG1_SSC];
	wire pattern_generator = cfg1_q[`CFG1_PATTERN_GENERATOR];
	wire loopAround = cfg0_q[`CFG0_LOOP];
	wire softRst = wr & aCfg2 & pwdata[`CFG2_SRST];
	wire intRst = reset | softRst;
	wire prpgStart = pattern_generator & ~pattern_generator_q;
	wire sscStart = signature_compactor & ~ssc_q;
	wire sscExit = ~signature_compactor & ssc_q;

	wire prpgSeeded = seedPtr_q == `PATTERN_GENERATOR_BYTES;
	wire sscSeeded = sigPtr_q == `SSC_BYTES;
	wire tdoHasData = pattern_generator ? prpgSeeded : tdoFull_q[tdoShSel_q]; // see R2
	wire tdiRoom = signature_compactor ? sscSeeded : ~tdiFull_q[tdiInSel_q]; // see R13
	wire cntOk = ~enab_q.cntEn | (cnt_q != `CNT_RESET);
	wire anyEn = enab_q.tdoEn | enab_q.tdiEn | enab_q.cntEn;
	// Loop-back selection is not a term here, so it never stalls the clock.
	wire shiftRun = anyEn & cntOk & ~stepArm_q & // see R16
		(~enab_q.tdoEn | tdoHasData) & (~enab_q.tdiEn | tdiRoom); // see R9
	wire rise = sck2_q & ~sck3_q;
	wire fall = ~sck2_q & sck3_q;
	wire doShift = rise & shiftRun;
	wire outShift = doShift & enab_q.tdoEn;
	wire inShift = doShift & enab_q.tdiEn;
	wire tcEvent = doShift & enab_q.cntEn & (cnt_q == 32'h1); // see R5
	wire byteDone = doShift & ((bitCnt_q == 3'h7) | tcEvent); // see R10
	wire step = rise & stepArm_q;

	wire tdoBit = pattern_generator ? lfsr_q[0] : tdoBuf_q[tdoShSel_q][bitCnt_q];
	wire prpgFb = lfsr_q[0] ^ lfsr_q[1] ^ lfsr_q[2] ^ lfsr_q[22]; // see R24
	loop_sel_t lbSel;
	assign lbSel = loop_sel_t'(cfg1_q[1:0]);
	logic inBit;
	always_comb begin
		unique case (lbSel) // see R15
			LB_OFF: inBit = tdi2_q;
			LB_TMS0: inBit = tms0Stream;
			LB_TMS1: inBit = tms1Stream;
			LB_TDO: inBit = tdoPin_q;
		endcase
	end
	wire sigFb = sig_q[15] ^ inBit;
	wire [15:0] sigNext = {sig_q[14:0], 1'b0} ^
		(sigFb ? `SSC_POLY : 16'h0000); // see R12

	wire cntWrite = wr & aCnt;
	wire tdoWrOk = pattern_generator | ~tdoFull_q[tdoWrSel_q];
	wire tdoWrite = wr & aTdo & tdoWrOk;
	wire tdiWrite = wr & aTdi & signature_compactor & ~sscSeeded; // see R8
	wire tdiRdOk = ~signature_compactor & tdiFull_q[tdiRdSel_q]; // see R7
	wire tdiRead = rd & aTdi & tdiRdOk;
	wire refused = (wr & aTdo & ~tdoWrOk) | (wr & aTdi & ~tdiWrite) |
		(rd & aTdi & ~tdiRdOk) | (wr & (aStat | aSeg));

	wire [7:0] statByte = {2'h0, prpgSeeded, sscSeeded, tdiFull_q,
		tdoFull_q};
	wire [7:0] segByte = cnt_q[{paddr[3:2], 3'h0} +: 8]; // see R21
	wire [31:0] rdMux = aCfg0 ? {24'h0, cfg0_q} :
		aCfg1 ? {24'h0, cfg1_q} :
		aEnab ? {28'h0, enab_q} :
		aTdi ? {24'h0, tdiBuf_q[tdiRdSel_q]} :
		aCnt ? cnt_q :
		aStat ? {24'h0, statByte} :
		aSeg ? {24'h0, segByte} : 32'h0;

	assign pready = 1'b1;
	assign pslverr = acc & (~mapped | refused);
	assign prdata = (rd & mapped & ~refused) ? rdMux : 32'h0;
	assign tdo = loopAround ? tdi2_q : tdoPin_q; // see R3
	assign tck = tck_q;

	always_ff @(posedge clk_sys) begin
		sck1_q <= sck;
		sck2_q <= sck1_q;
		sck3_q <= sck2_q;
		tdi1_q <= tdi;
		tdi2_q <= tdi1_q;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg0_q <= 8'h00;
			cfg1_q <= 8'h00;
			enab_q <= '0;
			pattern_generator_q <= 1'b0;
			ssc_q <= 1'b0;
		end else begin
			if (wr & aCfg0)
				cfg0_q <= pwdata[7:0];
			if (wr & aCfg1)
				cfg1_q <= pwdata[7:0];
			if (wr & aEnab)
				enab_q <= enables_t'(pwdata[3:0]);
			pattern_generator_q <= pattern_generator;
			ssc_q <= signature_compactor;
		end
	end

	// Arming is cleared by the step itself; a new arm wins over the clear.
	always_ff @(posedge clk_sys) begin
		if (intRst)
			stepArm_q <= 1'b0;
		else if (wr & aEnab & pwdata[3])
			stepArm_q <= 1'b1;
		else if (step)
			stepArm_q <= 1'b0;
	end

	// Soft reset does not reach the counter; only the pin reset does.
	always_ff @(posedge clk_sys) begin
		if (reset) begin // see R20
			cnt_q <= `CNT_RESET; // see R19
			cntPtr_q <= 2'h0;
		end else if (cntWrite) begin
			cnt_q[{cntPtr_q, 3'h0} +: 8] <= pwdata[7:0]; // see R17
			cntPtr_q <= cntPtr_q + 2'h1; // see R18
		end else begin
			if (wr)
				cntPtr_q <= 2'h0; // see R18
			if (((doShift & enab_q.cntEn) | step) & cnt_q != 32'h0)
				cnt_q <= cnt_q - 32'h1; // see R22 R23
		end
	end

	always_ff @(posedge clk_sys) begin
		if (intRst)
			bitCnt_q <= 3'h0;
		else if (byteDone)
			bitCnt_q <= 3'h0;
		else if (doShift)
			bitCnt_q <= bitCnt_q + 3'h1;
	end

	always_ff @(posedge clk_sys) begin
		if (intRst) begin
			tdoFull_q <= 2'h0;
			tdoWrSel_q <= 1'b0;
			tdoShSel_q <= 1'b0;
		end else if (!pattern_generator) begin
			if (tdoWrite) begin
				tdoBuf_q[tdoWrSel_q] <= pwdata[7:0];
				tdoWrSel_q <= ~tdoWrSel_q;
			end
			if (tdoWrite && !(outShift && byteDone &&
				tdoShSel_q == tdoWrSel_q))
				tdoFull_q[tdoWrSel_q] <= 1'b1;
			if (outShift & byteDone) begin
				tdoFull_q[tdoShSel_q] <= 1'b0; // see R5
				tdoShSel_q <= ~tdoShSel_q;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (intRst) begin
			lfsr_q <= 32'h0;
			seedPtr_q <= 3'h0;
		end else if (prpgStart) begin
			seedPtr_q <= 3'h0; // see R1
		end else if (pattern_generator) begin
			if (tdoWrite && !prpgSeeded) begin
				lfsr_q[{seedPtr_q[1:0], 3'h0} +: 8] <= pwdata[7:0];
				seedPtr_q <= seedPtr_q + 3'h1; // see R1
			end else if (outShift) begin
				lfsr_q <= {prpgFb, lfsr_q[31:1]};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tdoPin_q <= 1'b1;
			tck_q <= 1'b0;
		end else begin
			if (fall & shiftRun & enab_q.tdoEn)
				tdoPin_q <= tdoBit; // see R25
			if (doShift)
				tck_q <= 1'b1;
			else if (fall)
				tck_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (intRst) begin
			tdiFull_q <= 2'h0;
			tdiInSel_q <= 1'b0;
			tdiRdSel_q <= 1'b0;
		end else if (sscExit) begin
			tdiBuf_q[0] <= sig_q[15:8];
			tdiBuf_q[1] <= sig_q[7:0];
			tdiFull_q <= 2'h3; // see R14
			tdiRdSel_q <= 1'b0;
			tdiInSel_q <= 1'b0;
		end else if (!signature_compactor) begin
			if (inShift) begin
				tdiBuf_q[tdiInSel_q] <=
					{inBit, tdiBuf_q[tdiInSel_q][7:1]}; // see R6 R11
				if (byteDone) begin
					tdiFull_q[tdiInSel_q] <= 1'b1; // see R26
					tdiInSel_q <= ~tdiInSel_q; // see R10
				end
			end
			if (tdiRead) begin
				tdiFull_q[tdiRdSel_q] <= 1'b0;
				tdiRdSel_q <= ~tdiRdSel_q;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (intRst) begin
			sig_q <= 16'h0;
			sigPtr_q <= 2'h0;
		end else if (sscStart) begin
			sigPtr_q <= 2'h0;
		end else if (tdiWrite) begin
			if (sigPtr_q == 2'h0)
				sig_q[15:8] <= pwdata[7:0]; // see R13
			else
				sig_q[7:0] <= pwdata[7:0];
			sigPtr_q <= sigPtr_q + 2'h1;
		end else if (signature_compactor & inShift) begin
			sig_q <= sigNext; // see R12
		end
	end

	a_cnt_nowrap: assert property (@(posedge clk_sys) disable iff (reset)
		cnt_q == 32'h0 && !cntWrite |=> cnt_q == 32'h0) // see R23
		else $error("counter wrapped below zero");
	a_cnt_decrement: assert property (@(posedge clk_sys) disable iff (reset)
		doShift && enab_q.cntEn && cnt_q != 32'h0 && !cntWrite
		|=> cnt_q == $past(cnt_q) - 32'h1) // see R17
		else $error("counter did not decrement");
	a_seed_holds_shift: assert property (@(posedge clk_sys)
		disable iff (reset)
		pattern_generator && !prpgSeeded && enab_q.tdoEn |-> !doShift) // see R2
		else $error("shift before generator seeded");
	a_tdi_read_refused: assert property (@(posedge clk_sys)
		disable iff (reset)
		rd && aTdi && (signature_compactor || !tdiFull_q[tdiRdSel_q]) |-> pslverr) // see R7
		else $error("illegal incoming read accepted");
	a_tdi_write_ignored: assert property (@(posedge clk_sys)
		disable iff (reset)
		wr && aTdi && !signature_compactor && !sscExit |=> $stable(sig_q)) // see R8
		else $error("incoming write outside signature mode");
	a_soft_keeps_cnt: assert property (@(posedge clk_sys)
		disable iff (reset)
		softRst && !step && !(doShift && enab_q.cntEn)
		|=> $stable(cnt_q)) // see R20
		else $error("soft reset changed counter");
	a_step_no_tck: assert property (@(posedge clk_sys) disable iff (reset)
		stepArm_q |=> !$rose(tck_q)) // see R22
		else $error("scan clock toggled in single step");
	a_ssc_exit_full: assert property (@(posedge clk_sys) disable iff (reset)
		sscExit && !softRst |=> tdiFull_q == 2'h3 && !tdiRdSel_q) // see R14
		else $error("signature not ready after exit");
	a_tc_switches: assert property (@(posedge clk_sys) disable iff (reset)
		tcEvent && enab_q.tdoEn && !pattern_generator && !softRst
		|=> tdoShSel_q != $past(tdoShSel_q)) // see R5
		else $error("terminal count did not switch register");
	a_tdi_msb_entry: assert property (@(posedge clk_sys) disable iff (reset)
		inShift && !signature_compactor && !softRst && !sscExit
		|=> tdiBuf_q[$past(tdiInSel_q)][7] == $past(inBit)) // see R11
		else $error("incoming bit not at top position");
endmodule

// ---- rtl/scan_shifter_regs.svh ----
// Register offsets, field positions and constants of the scan shifter.
`ifndef SCAN_SHIFTER_REGS_SVH
`define SCAN_SHIFTER_REGS_SVH
`define OFS_CFG0 12'h000
`define OFS_CFG1 12'h004
`define OFS_CFG2 12'h008
`define OFS_ENAB 12'h00c
`define OFS_TDO 12'h010
`define OFS_TDI 12'h014
`define OFS_CNT 12'h018
`define OFS_STAT 12'h01c
`define OFS_SEG0 12'h020
`define OFS_SEG3 12'h02c
`define CFG0_LOOP 0
`define CFG1_SSC 3
`define CFG1_PATTERN_GENERATOR 4
`define CFG2_SRST 1
`define PATTERN_GENERATOR_BYTES 3'h4
`define SSC_BYTES 2'h2
`define SSC_POLY 16'h100b
`define CNT_RESET 32'h0000_0000
`endif

// ---- rtl/scan_shifter_pkg.sv ----
// Types shared by the scan shifter design.
package scan_shifter_pkg;
	typedef enum logic [1:0] {
		LB_OFF = 2'h0,
		LB_TMS0 = 2'h1,
		LB_TMS1 = 2'h2,
		LB_TDO = 2'h3
	} loop_sel_t;
	typedef struct packed {
		logic stepMode;
		logic cntEn;
		logic tdiEn;
		logic tdoEn;
	} enables_t;
endpackage

// ---- tb/scan_chain_model.sv ----
// Scan chain model: link clock, returning data and captured outgoing data.
`timescale 1ns/1ps
module scan_chain_model (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic load,
	input wire logic [7:0] loadVal,
	input wire logic tck,
	input wire logic tdo,
	output logic sck,
	output logic tdi,
	output logic [7:0] got
);
	logic [7:0] pat_q;
	logic sckPrev_q;
	logic tckPrev_q;
	assign tdi = pat_q[0];
	// The link clock finishes its period and then stands still at high.
	// Every frame thus opens with a falling edge, which puts the first
	// outgoing bit on the line before the first rising scan clock.
	initial begin
		sck = 1'b1;
		#7;
		forever begin
			#160;
			if (run || !sck) begin
				sck = ~sck;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		sckPrev_q <= sck;
		tckPrev_q <= tck;
		if (load) begin
			pat_q <= loadVal;
			got <= 8'h00;
		end else begin
			// Used bits are replaced by ones, the level of the pulled-up line.
			if (sckPrev_q && !sck && tck) begin
				pat_q <= {1'b1, pat_q[7:1]};
			end
			// The chain takes outgoing data on the rising scan clock.
			if (!tckPrev_q && tck) begin
				got <= {tdo, got[7:1]};
			end
		end
	end
endmodule

// ---- tb/scan_shifter_signature_counter_tb_top.sv ----
// Self-checking bench for the scan shifter behind APB.
`timescale 1ns/1ps
`include "scan_shifter_regs.svh"
module scan_shifter_signature_counter_tb_top;
	import scan_shifter_pkg::*;
	logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sck, tdi, tms0Stream, tms1Stream, tdo, tck, run, load, err;
	logic [7:0] loadVal, got;
	logic [15:0] sig;
	int fail_count, check_count, tckRises;
	scan_shifter_signature_counter u_dut (.clk_sys(clk_sys), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sck(sck), .tdi(tdi), .tms0Stream(tms0Stream),
		.tms1Stream(tms1Stream), .tdo(tdo), .tck(tck));
	scan_chain_model u_chain (.clk_sys(clk_sys), .run(run), .load(load),
		.loadVal(loadVal), .tck(tck), .tdo(tdo), .sck(sck), .tdi(tdi),
		.got(got));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge tck) tckRises++;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check32(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rchk(input string what, input logic [11:0] a,
		input logic [31:0] exp, input logic expErr);
		apb(1'b0, a, 32'h0);
		check32(what, exp, rd);
		check32({what, " err"}, {31'h0, expErr}, {31'h0, err});
	endtask
	task automatic load_cnt(input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `OFS_CNT, {24'h0, v[8*i +: 8]});
		end
	endtask
	task automatic lpat(input logic [7:0] v);
		load <= 1'b1;
		loadVal <= v;
		@(posedge clk_sys);
		load <= 1'b0;
		tckRises = 0;
	endtask
	task automatic run_sck(input int n);
		run <= 1'b1;
		repeat (8 * n) @(posedge clk_sys);
		run <= 1'b0;
		repeat (24) @(posedge clk_sys);
	endtask
	task automatic clr();
		apb(1'b1, `OFS_ENAB, 32'h0);
		apb(1'b1, `OFS_CFG1, 32'h0);
		apb(1'b1, `OFS_CFG0, 32'h0);
		apb(1'b1, `OFS_CFG2, 32'h2);
	endtask
	task automatic t_counter();
		rchk("cnt rst", `OFS_CNT, `CNT_RESET, 1'b0);
		rchk("unmapped", 12'h100, 32'h0, 1'b1);
		apb(1'b1, `OFS_CNT, 32'haa);
		apb(1'b1, `OFS_CFG0, 32'h0);
		load_cnt(32'h0403_0201);
		rchk("restart", `OFS_CNT, 32'h0403_0201, 1'b0);
		load_cnt(32'h0100_0000);
		apb(1'b1, `OFS_ENAB, 32'h8);
		lpat(8'hff);
		run_sck(3);
		rchk("step", `OFS_CNT, 32'h00ff_ffff, 1'b0);
		rchk("seg0", `OFS_SEG0, 32'hff, 1'b0);
		check32("step tck", 0, tckRises);
		apb(1'b1, `OFS_CFG2, 32'h2);
		rchk("soft", `OFS_CNT, 32'h00ff_ffff, 1'b0);
		load_cnt(32'h0);
		apb(1'b1, `OFS_ENAB, 32'h8);
		run_sck(2);
		rchk("zero", `OFS_CNT, 32'h0, 1'b0);
		$display("done counter");
	endtask
	task automatic t_loop();
		check32("tdo idle", 1, tdo);
		apb(1'b1, `OFS_CFG0, 32'h1);
		for (int v = 0; v < 2; v++) begin
			lpat({8{v[0]}});
			repeat (4) @(posedge clk_sys);
			check32("loop", v, tdo);
		end
		$display("done loop");
	endtask
	task automatic t_rx();
		clr();
		load_cnt(32'h5);
		apb(1'b1, `OFS_TDI, 32'h5a);
		check32("tdi wr", 1, err);
		apb(1'b1, `OFS_ENAB, 32'h6);
		lpat(8'h16);
		run_sck(8);
		check32("rx shifts", 5, tckRises);
		rchk("cnt tc", `OFS_CNT, 32'h0, 1'b0);
		apb(1'b0, `OFS_TDI, 32'h0);
		check32("partial", 32'hb0, rd & 32'hf8);
		rchk("empty", `OFS_TDI, 32'h0, 1'b1);
		$display("done rx");
	endtask
	task automatic t_tx();
		clr();
		load_cnt(32'h3);
		apb(1'b1, `OFS_TDO, 32'ha5);
		apb(1'b1, `OFS_ENAB, 32'h5);
		lpat(8'hff);
		run_sck(6);
		check32("tx bits", 5, {29'h0, got[7:5]});
		check32("tx shifts", 3, tckRises);
		apb(1'b1, `OFS_TDO, 32'h03);
		load_cnt(32'h2);
		lpat(8'hff);
		run_sck(5);
		check32("tx fresh", 3, {30'h0, got[7:6]});
		$display("done tx");
	endtask
	task automatic t_ssc();
		clr();
		load_cnt(32'h4);
		tms0Stream <= 1'b1;
		apb(1'b1, `OFS_CFG1, 32'h8 | 32'(LB_TMS0));
		apb(1'b1, `OFS_TDI, 32'h12);
		apb(1'b1, `OFS_TDI, 32'h34);
		apb(1'b1, `OFS_TDI, 32'h56);
		check32("seed extra", 1, err);
		rchk("ssc rd", `OFS_TDI, 32'h0, 1'b1);
		apb(1'b1, `OFS_ENAB, 32'h6);
		lpat(8'h00);
		run_sck(8);
		check32("ssc tck", 4, tckRises);
		sig = 16'h1234;
		for (int i = 0; i < 4; i++) begin
			sig = {sig[14:0], 1'b0} ^ (sig[15] ? 16'h0 : `SSC_POLY);
		end
		apb(1'b1, `OFS_CFG1, 32'h0);
		rchk("sig msb", `OFS_TDI, {24'h0, sig[15:8]}, 1'b0);
		rchk("sig lsb", `OFS_TDI, {24'h0, sig[7:0]}, 1'b0);
		$display("done ssc");
	endtask
	task automatic t_lback();
		clr();
		load_cnt(32'h8);
		apb(1'b1, `OFS_CFG1, 32'(LB_TDO));
		apb(1'b1, `OFS_TDO, 32'h3c);
		apb(1'b1, `OFS_ENAB, 32'h7);
		lpat(8'h00);
		run_sck(12);
		check32("lb tck", 8, tckRises);
		check32("lb chain", 32'h3c, {24'h0, got});
		rchk("lb tdi", `OFS_TDI, 32'h3c, 1'b0);
		$display("done loopback");
	endtask
	task automatic t_pattern_generator();
		clr();
		load_cnt(32'h2);
		apb(1'b1, `OFS_CFG1, 32'h10);
		apb(1'b1, `OFS_TDO, 32'h01);
		apb(1'b1, `OFS_TDO, 32'h00);
		apb(1'b1, `OFS_TDO, 32'h00);
		apb(1'b1, `OFS_ENAB, 32'h5);
		lpat(8'hff);
		run_sck(3);
		check32("unseeded", 0, tckRises);
		apb(1'b1, `OFS_TDO, 32'h00);
		run_sck(6);
		check32("pattern_generator tck", 2, tckRises);
		check32("pattern_generator bits", 1, {30'h0, got[7:6]});
		$display("done pattern_generator");
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end
	initial begin
		{reset, load} = 2'b11;
		{psel, penable, pwrite, run, tms0Stream, tms1Stream} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		loadVal = 8'hff;
		{fail_count, check_count, tckRises} = 0;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		load <= 1'b0;
		t_counter();
		t_loop();
		t_rx();
		t_tx();
		t_ssc();
		t_lback();
		t_pattern_generator();
		report_and_stop();
	end
endmodule
